// *** logic/blank_scan.sv ***
`timescale 1ns/1ps
`default_nettype none
module blank_scan
    import flash_status_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    // Control
    input  wire logic                start,
    output logic                     done,
    output logic                     not_blank,
    // Array port
    output logic                     arr_rd,
    output logic [WORD_A_W-1:0]      arr_addr,
    input  wire logic [DATA_W-1:0]   arr_data
);

    logic                busy_r;
    logic                check_r;
    logic [WORD_A_W-1:0] addr_r;
    logic                done_r;
    logic                fail_r;

    assign arr_rd    = busy_r && !check_r;
    assign arr_addr  = addr_r;
    assign done      = done_r;
    assign not_blank = fail_r;

    // Alternate request and compare; stop on the first unerased word
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busy_r  <= 1'b0;
            check_r <= 1'b0;
            addr_r  <= '0;
            done_r  <= 1'b0;
            fail_r  <= 1'b0;
        end else if (clk_en) begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                busy_r  <= 1'b1;
                check_r <= 1'b0;
                addr_r  <= '0;
                fail_r  <= 1'b0;
            end else if (busy_r && !check_r) begin
                check_r <= 1'b1;
            end else if (busy_r) begin
                check_r <= 1'b0;
                if (arr_data != ERASED_WORD) begin // R22
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    fail_r <= 1'b1;
                end else if (&addr_r) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    addr_r <= addr_r + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** logic/flash_status_and_blank_check.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: Each status read needs a status-read command, then one status read.
// R02: Ready flag is one only when no program or erase runs.
// R03: Status bits 1 to 6 are meaningful only while ready is one.
// R04: Failed or aborted program sets program result; clear-status clears it.
// R05: Erase result holds outcome of latest erase: zero ok, one error.
// R06: Erase result cleared by clear-status command and hardware reset.
// R07: After program suspend host polls until ready before same-bank access.
// R08: Program-suspended flag reads one while suspended; resume clears it.
// R09: Locked-sector flag set when program or erase refused on locked sector.
// R10: Locked-sector flag reflects only the most recent program or erase.
// R11: Locked-sector flag cleared by clear-status command and hardware reset.
// R12: Bank flag: busy here 0, busy elsewhere 1, ready 0.
// R13: Blank check tests every bit of one sector for the erased state.
// R14: Array reads are not serviced while blank check runs.
// R15: Blank check runs only when asynchronous read mode is selected.
// R16: Host starts blank check writing 33h at offset AAAh of sector.
// R17: Host issues blank check only from idle, never during suspend.
// R18: No blank check during program or erase; no parallel bank activity.
// R19: Host polls status to learn completion and blank result.
// R20: Blank check writes bit 5: zero if erased, one otherwise.
// R21: Ready and bank flags show busy during blank check, as for erase.
// R22: Scan stops at first unerased bit and reports at once.
// R23: Blank check completion returns the device to idle.
// R24: Reserved status bit 3 always reads zero.
module flash_status_and_blank_check
    import flash_status_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    // Configuration
    input  wire logic                  async_read_select,
    // Command writes
    input  wire logic                  cmd_wr,
    input  wire cmd_write_t            cmd,
    // Status read
    input  wire logic                  stat_rd,
    input  wire logic [BANK_W-1:0]     stat_bank,
    output logic                       stat_valid,
    output logic [STAT_W-1:0]          status_word,
    // Embedded program and erase engine
    input  wire logic                  prog_start,
    input  wire logic                  erase_start,
    input  wire logic [BANK_W-1:0]     op_bank,
    input  wire op_result_t            op_result,
    output logic                       engine_hold,
    // Array access
    output logic                       array_read_inhibit,
    output logic                       arr_rd,
    output logic [SECTOR_W-1:0]        arr_sector,
    output logic [WORD_A_W-1:0]        arr_addr,
    input  wire logic [DATA_W-1:0]     arr_data
);

    op_state_t           state_r;
    op_state_t           state_nxt;
    logic [BANK_W-1:0]   busy_bank_r;
    logic [SECTOR_W-1:0] blank_sector_r;
    logic                armed_r;
    logic                erase_res_r;
    logic                prog_res_r;
    logic                locked_r;
    logic                prog_susp_r;
    logic                erase_susp_r;
    logic                stat_valid_r;
    logic [STAT_W-1:0]   status_word_r;
    logic                scan_start;
    logic                scan_done;
    logic                scan_fail;
    logic [STAT_W-1:0]   live_word;

    logic is_clear;
    logic is_psusp;
    logic is_presume;
    logic is_esusp;
    logic is_eresume;
    logic is_blank;
    logic ready;

    assign is_clear   = cmd_wr && cmd.data == CMD_CLEAR_STATUS;
    assign is_psusp   = cmd_wr && cmd.data == CMD_PROG_SUSPEND && state_r == ST_PROG;
    assign is_presume = cmd_wr && cmd.data == CMD_PROG_RESUME && prog_susp_r;
    assign is_esusp   = cmd_wr && cmd.data == CMD_ERASE_SUSP && state_r == ST_ERASE;
    assign is_eresume = cmd_wr && cmd.data == CMD_ERASE_RESUME && erase_susp_r
                        && !prog_susp_r;
    // Accepted only when idle, unsuspended and in async read mode
    assign is_blank   = cmd_wr && cmd.data == CMD_BLANK_CHECK
                        && cmd.offset == OFS_BLANK_CHECK
                        && state_r == ST_IDLE && !prog_susp_r && !erase_susp_r // R18
                        && async_read_select; // R15
    assign scan_start = is_blank; // R13

    assign ready = (state_r == ST_IDLE); // R02

    // Operation state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (is_blank) begin
                    state_nxt = ST_BLANK;
                end else if (is_presume) begin
                    state_nxt = ST_PROG;
                end else if (is_eresume) begin
                    state_nxt = ST_ERASE;
                end else if (prog_start) begin
                    state_nxt = ST_PROG;
                end else if (erase_start && !erase_susp_r) begin
                    state_nxt = ST_ERASE;
                end
            end
            ST_PROG: begin
                if (op_result.done || is_psusp) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ERASE: begin
                if (op_result.done || is_esusp) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_BLANK: begin
                if (scan_done) begin
                    state_nxt = ST_IDLE; // R23
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // Bank of the running operation
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busy_bank_r    <= '0;
            blank_sector_r <= '0;
        end else if (clk_en) begin
            if (state_r == ST_IDLE && (prog_start || erase_start)) begin
                busy_bank_r <= op_bank;
            end
            if (is_blank) begin
                busy_bank_r    <= cmd.bank;
                blank_sector_r <= cmd.sector;
            end
        end
    end

    // Suspend flags
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prog_susp_r  <= 1'b0;
            erase_susp_r <= 1'b0;
        end else if (clk_en) begin
            if (is_psusp) begin
                prog_susp_r <= 1'b1; // R08
            end else if (is_presume) begin
                prog_susp_r <= 1'b0; // R08
            end
            if (is_esusp) begin
                erase_susp_r <= 1'b1;
            end else if (is_eresume) begin
                erase_susp_r <= 1'b0;
            end
        end
    end

    // Result flags; completion wins over a same-cycle clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            erase_res_r <= 1'b0; // R06
            prog_res_r  <= 1'b0;
            locked_r    <= 1'b0; // R11
        end else if (clk_en) begin
            if (is_clear) begin
                erase_res_r <= 1'b0; // R06
                prog_res_r  <= 1'b0; // R04
                locked_r    <= 1'b0; // R11
            end
            if (state_r == ST_ERASE && op_result.done) begin
                erase_res_r <= op_result.fail; // R05
                locked_r    <= op_result.locked; // R09 R10
            end
            if (state_r == ST_PROG && op_result.done) begin
                prog_res_r <= op_result.fail; // R04
                locked_r   <= op_result.locked; // R09 R10
            end
            if (state_r == ST_BLANK && scan_done) begin
                erase_res_r <= scan_fail; // R20
            end
        end
    end

    // Live status; bank flag only set while busy elsewhere
    always_comb begin
        live_word                 = '0;
        live_word[BIT_READY]      = ready;
        live_word[BIT_BANK_BUSY]  = !ready && (busy_bank_r != stat_bank); // R12 R21
        if (ready) begin // R03
            live_word[BIT_ERASE_SUSP] = erase_susp_r;
            live_word[BIT_ERASE_RES]  = erase_res_r;
            live_word[BIT_PROG_RES]   = prog_res_r;
            live_word[BIT_PROG_SUSP]  = prog_susp_r;
            live_word[BIT_LOCKED]     = locked_r;
        end
        live_word[BIT_RESERVED] = 1'b0; // R24
    end

    // Status-read command arms exactly one read
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            armed_r       <= 1'b0;
            stat_valid_r  <= 1'b0;
            status_word_r <= STAT_RESET;
        end else if (clk_en) begin
            stat_valid_r <= 1'b0;
            if (cmd_wr && cmd.data == CMD_STATUS_READ) begin
                armed_r <= 1'b1; // R01
            end else if (stat_rd && armed_r) begin
                armed_r       <= 1'b0; // R01
                stat_valid_r  <= 1'b1;
                status_word_r <= live_word;
            end
        end
    end

    assign stat_valid         = stat_valid_r;
    assign status_word        = status_word_r;
    assign engine_hold        = prog_susp_r || erase_susp_r;
    assign array_read_inhibit = (state_r == ST_BLANK); // R14
    assign arr_sector         = blank_sector_r;

    blank_scan u_scan (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .start     (scan_start),
        .done      (scan_done),
        .not_blank (scan_fail),
        .arr_rd    (arr_rd),
        .arr_addr  (arr_addr),
        .arr_data  (arr_data)
    );

endmodule
`default_nettype wire

// *** logic/flash_status_pkg.sv ***
package flash_status_pkg;

    // Status word layout
    localparam int STAT_W          = 16;
    localparam int BIT_READY       = 7;
    localparam int BIT_ERASE_SUSP  = 6;
    localparam int BIT_ERASE_RES   = 5;
    localparam int BIT_PROG_RES    = 4;
    localparam int BIT_RESERVED    = 3;
    localparam int BIT_PROG_SUSP   = 2;
    localparam int BIT_LOCKED      = 1;
    localparam int BIT_BANK_BUSY   = 0;
    localparam logic [15:0] STAT_RESET = 16'h0080;

    // Bus and array geometry
    localparam int CMD_W     = 8;
    localparam int OFS_W     = 12;
    localparam int SECTOR_W  = 8;
    localparam int BANK_W    = 4;
    localparam int WORD_A_W  = 16;
    localparam int DATA_W    = 16;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

    // Command codes
    localparam logic [CMD_W-1:0] CMD_STATUS_READ  = 8'h70;
    localparam logic [CMD_W-1:0] CMD_CLEAR_STATUS = 8'h71;
    localparam logic [CMD_W-1:0] CMD_PROG_SUSPEND = 8'h51;
    localparam logic [CMD_W-1:0] CMD_PROG_RESUME  = 8'h50;
    localparam logic [CMD_W-1:0] CMD_ERASE_SUSP   = 8'hb0;
    localparam logic [CMD_W-1:0] CMD_ERASE_RESUME = 8'h30;
    localparam logic [CMD_W-1:0] CMD_BLANK_CHECK  = 8'h33;
    localparam logic [OFS_W-1:0] OFS_BLANK_CHECK  = 12'haaa;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PROG  = 2'b01,
        ST_ERASE = 2'b11,
        ST_BLANK = 2'b10
    } op_state_t;

    typedef struct packed {
        logic [SECTOR_W-1:0] sector;
        logic [BANK_W-1:0]   bank;
        logic [OFS_W-1:0]    offset;
        logic [CMD_W-1:0]    data;
    } cmd_write_t;

    typedef struct packed {
        logic              done;
        logic              fail;
        logic              locked;
    } op_result_t;

endpackage

// *** test/flash_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
    import flash_status_pkg::*;
(
    // Clock
    input wire logic                sys_clk,
    // Scan port
    input wire logic                arr_rd,
    input wire logic [WORD_A_W-1:0] arr_addr,
    output logic [DATA_W-1:0]       arr_data,
    // Fault placement
    input wire logic [WORD_A_W-1:0] dirty_addr,
    input wire logic [3:0]          dirty_bit
);
    initial arr_data = 16'h0000;
    // Word valid the cycle after a read, scrambled otherwise
    always @(posedge sys_clk) begin
        if (arr_rd)
            arr_data <= (arr_addr == dirty_addr) ? ERASED_WORD & ~(16'h0001 << dirty_bit)
                                                 : ERASED_WORD;
        else
            arr_data <= ~arr_data;
    end
endmodule
`default_nettype wire

// *** test/flash_status_and_blank_check_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_status_and_blank_check_tb;
    import flash_status_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, async_read_select = 1'b0, cmd_wr = 1'b0;
    logic stat_rd = 1'b0, prog_start = 1'b0, erase_start = 1'b0;
    logic stat_valid, array_read_inhibit, arr_rd;
    logic clk_en = 1'b1, engine_hold;
    logic [SECTOR_W-1:0] arr_sector;
    cmd_write_t cmd = '0;
    op_result_t op_result = '0;
    logic [BANK_W-1:0] stat_bank = '0, op_bank = '0;
    logic [STAT_W-1:0] status_word;
    logic [WORD_A_W-1:0] arr_addr, dirty_addr = '0;
    logic [DATA_W-1:0] arr_data;
    logic [3:0] dirty_bit = '0;
    logic [STAT_W-1:0] exp_q[$];
    logic [31:0] rng = 32'h87e3;
    int fail_count = 0, checks_done = 0, inh_cnt = 0;

    always #20 sys_clk = ~sys_clk;

    flash_status_and_blank_check dut_u (.sys_clk, .reset, .clk_en, .async_read_select,
        .cmd_wr, .cmd, .stat_rd, .stat_bank, .stat_valid, .status_word, .prog_start,
        .erase_start, .op_bank, .op_result, .engine_hold, .array_read_inhibit, .arr_rd,
        .arr_sector, .arr_addr, .arr_data);
    flash_array_model mdl_u (.sys_clk, .arr_rd, .arr_addr, .arr_data, .dirty_addr, .dirty_bit);

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task tick; @(posedge sys_clk); #1; endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [CMD_W-1:0] d, input logic [OFS_W-1:0] o = 12'h000);
        cmd_wr = 1'b1;
        cmd = '{rng[7:0], 4'h1, o, d};
        tick;
        cmd_wr = 1'b0;
        tick;
    endtask
    task stat(input logic [BANK_W-1:0] b, input logic [STAT_W-1:0] e);
        wr(CMD_STATUS_READ);
        stat_rd = 1'b1;
        stat_bank = b;
        exp_q.push_back(e);
        tick;
        stat_rd = 1'b0;
        tick;
    endtask
    task op(input logic p, input logic [BANK_W-1:0] b);
        prog_start = p;
        erase_start = !p;
        op_bank = b;
        tick;
        prog_start = 1'b0;
        erase_start = 1'b0;
        tick;
    endtask
    task fin(input logic f, input logic l);
        op_result = '{1'b1, f, l};
        tick;
        op_result = '0;
        tick;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(negedge sys_clk) begin
        if (array_read_inhibit === 1'b1)
            inh_cnt++;
        if (stat_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unasked status", 0, 1);
            else
                chk("status_word", exp_q.pop_front(), status_word);
        end
    end

    initial begin
        #(40 * 4000);
        fail_count++;
        finish_test;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1 reset = 1'b0;
        tick;
        stat(4'h0, 16'h0080);
        stat_rd = 1'b1;
        tick;
        stat_rd = 1'b0;
        tick;
        $display("reset and arming done");
        op(1'b1, 4'h2);
        stat(4'h2, 16'h0000);
        stat(4'h5, 16'h0001);
        fin(1'b1, 1'b0);
        stat(4'h2, 16'h0090);
        wr(CMD_CLEAR_STATUS);
        stat(4'h2, 16'h0080);
        op(1'b1, 4'h2);
        clk_en = 1'b0;
        fin(1'b1, 1'b1);
        clk_en = 1'b1;
        stat(4'h2, 16'h0000);
        fin(1'b0, 1'b0);
        stat(4'h2, 16'h0080);
        op(1'b0, 4'h3);
        fin(1'b1, 1'b1);
        stat(4'h3, 16'h00a2);
        op(1'b1, 4'h3);
        fin(1'b0, 1'b0);
        stat(4'h3, 16'h00a0);
        wr(CMD_CLEAR_STATUS);
        stat(4'h3, 16'h0080);
        op(1'b0, 4'h3);
        fin(1'b1, 1'b1);
        reset = 1'b1;
        tick;
        tick;
        reset = 1'b0;
        tick;
        stat(4'h3, 16'h0080);
        $display("result flags done");
        op(1'b1, 4'h6);
        wr(CMD_PROG_SUSPEND);
        chk("engine_hold", 1, engine_hold);
        stat(4'h6, 16'h0084);
        async_read_select = 1'b1;
        wr(CMD_BLANK_CHECK, OFS_BLANK_CHECK);
        chk("inhibit", 0, array_read_inhibit);
        wr(CMD_PROG_RESUME);
        chk("engine_hold", 0, engine_hold);
        stat(4'h6, 16'h0000);
        fin(1'b0, 1'b0);
        stat(4'h6, 16'h0080);
        op(1'b0, 4'h6);
        wr(CMD_ERASE_SUSP);
        stat(4'h6, 16'h00c0);
        op(1'b0, 4'h6);
        stat(4'h6, 16'h00c0);
        wr(CMD_ERASE_RESUME);
        fin(1'b0, 1'b0);
        stat(4'h6, 16'h0080);
        $display("suspend done");
        async_read_select = 1'b0;
        wr(CMD_BLANK_CHECK, OFS_BLANK_CHECK);
        chk("inhibit", 0, array_read_inhibit);
        async_read_select = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            dirty_addr = (i == 0) ? 16'h0000 : {10'h000, rng[13:8]} + 16'h0008;
            dirty_bit = rng[19:16];
            inh_cnt = 0;
            wr(CMD_BLANK_CHECK, OFS_BLANK_CHECK);
            chk("arr_sector", rng[7:0], arr_sector);
            if (i > 0) begin
                stat(4'h1, 16'h0000);
                stat(4'h4, 16'h0001);
            end
            for (int t = 0; t < 300 && array_read_inhibit !== 1'b0; t++)
                tick;
            // Two cycles per word read, plus the cycle of the done pulse
            chk("scan cycles", 2 * (dirty_addr + 1) + 1, inh_cnt);
            stat(4'h1, 16'h00a0);
            wr(CMD_CLEAR_STATUS);
        end
        chk("pending answers", 0, exp_q.size());
        $display("blank check done");
        finish_test;
    end
endmodule

bind flash_status_and_blank_check flash_status_asserts chk_u (.sys_clk, .reset,
    .async_read_select, .cmd_wr, .cmd, .stat_rd, .stat_valid, .status_word, .arr_rd,
    .arr_data, .array_read_inhibit);
`default_nettype wire

// *** test/flash_status_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_status_asserts
    import flash_status_pkg::*;
(
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset,
    // Watched ports
    input wire logic              async_read_select,
    input wire logic              cmd_wr,
    input wire cmd_write_t        cmd,
    input wire logic              stat_rd,
    input wire logic              stat_valid,
    input wire logic [STAT_W-1:0] status_word,
    input wire logic              arr_rd,
    input wire logic [DATA_W-1:0] arr_data,
    input wire logic              array_read_inhibit
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic blank_cmd;
    assign blank_cmd = cmd_wr && cmd.data == CMD_BLANK_CHECK && cmd.offset == OFS_BLANK_CHECK;
    a_reserved_bits_zero: assert property (stat_valid |-> !status_word[3])
        else $error("reserved status bit set");
    a_busy_hides_bits: assert property (stat_valid && !status_word[7]
        |-> status_word[6:1] == 6'h00)
        else $error("result bits shown while busy");
    a_ready_bank_clear: assert property (stat_valid && status_word[7] |-> !status_word[0])
        else $error("bank flag set while ready");
    a_armed_read_answer: assert property ((cmd_wr && cmd.data == CMD_STATUS_READ)
        ##1 !stat_rd ##1 stat_rd |=> stat_valid)
        else $error("armed status read not answered");
    a_answer_needs_read: assert property (stat_valid |-> $past(stat_rd))
        else $error("status answer without read");
    a_word_holds: assert property (!stat_valid |-> $stable(status_word))
        else $error("status word changed unanswered");
    a_inhibit_covers_scan: assert property (arr_rd |-> array_read_inhibit)
        else $error("scan read without inhibit");
    a_sync_mode_refused: assert property (blank_cmd && !async_read_select
        && !array_read_inhibit |=> !array_read_inhibit)
        else $error("blank check started in sync mode");
    // Read stops at once; idle follows one cycle after the done pulse
    a_first_dirty_stops: assert property (arr_rd ##1 (arr_data != ERASED_WORD)
        |=> !arr_rd ##1 !array_read_inhibit)
        else $error("scan went on past unerased word");
    cover property (stat_valid && !status_word[7]);
    cover property (blank_cmd && async_read_select);
    cover property (arr_rd ##1 arr_data != ERASED_WORD);
endmodule
`default_nettype wire
